// ==== rtl/fco_top.sv ====
// Flash clock divider, option register, backdoor key and security gate
`timescale 1ns/1ps
`include "fco_defines.svh"
module fco_top #(
  parameter int KEY_BYTES = 8
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Bus source qualifiers, valid in address phase
  input  wire logic        src_secure_code,
  input  wire logic        src_background_debug,
  // Nonvolatile contents
  input  wire logic [7:0]  stored_option_byte,
  input  wire logic [63:0] stored_backdoor_key,
  input  wire logic        blank_check_ok,
  // Program and erase sequencer
  input  wire logic        pe_start,
  input  wire logic [15:0] pe_pulse_count,
  output logic             pe_busy_q,
  output logic             pe_done_q,
  output logic             pe_refused_q,
  output logic             fclk_tick_q,
  // Option outputs
  output logic [7:0]       flash_option_reg_q,
  output logic             secure_q,
  output logic             vector_redirect_en_q,
  // Memory access gate
  input  wire logic        mem_req,
  input  wire logic        mem_req_trusted,
  input  wire logic        mem_we_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic             mem_we_q,
  output logic [7:0]       mem_rdata_q
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  generate
    if (KEY_BYTES != 8) begin : g_bad_key
      $error("fco_top: KEY_BYTES must be 8");
    end
  endgenerate

  fco_pkg::fco_state_t q, d;
  logic                tick;
  logic                take;
  logic                blocked;
  logic [7:0]          kbyte;
  logic                new_kacc;

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input fco_pkg::fco_state_t s);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      `FCO_OFS_CDIV: begin
        r[`FCO_DIVISOR_LOADED_FLAG_BIT] = s.divisor_loaded_flag;
        r[6:0] = s.cdiv;
      end
      `FCO_OFS_OPT: begin
        r[7:0] = s.flash_option_reg;
      end
      `FCO_OFS_CTRL: begin
        r[`FCO_KACC_BIT] = (s.kst == fco_pkg::FCO_KEY_OPEN);
        r[`FCO_ST_SEC_BIT] = s.secure;
        r[`FCO_ST_BSY_BIT] = s.busy;
        r[`FCO_ST_KEY_BIT] = s.kmatch;
      end
      default: begin
        r = 32'h0;
      end
    endcase
    return r;
  endfunction

  function automatic logic is_secure(input logic [1:0] code);
    return code != `FCO_SEC_UNSEC;
  endfunction

  // ------------------------------------------------------------
  // Flash clock
  // ------------------------------------------------------------
  fco_clkdiv u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (q.divisor_loaded_flag),
    .prescale_by_eight  (q.cdiv[`FCO_PRDIV_BIT]),
    .div     (q.cdiv[5:0]),
    .tick_q  (tick)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  assign take = hsel && htrans[1] && hready;
  assign kbyte = stored_backdoor_key[q.kidx[2:0]*8 +: 8];
  assign blocked = q.secure && !mem_req_trusted;
  assign new_kacc = hwdata[`FCO_KACC_BIT];

  always_comb begin
    d = q;
    d.hready = 1'b1;
    d.done = 1'b0;
    d.refused = 1'b0;
    // Copy happens on the first edge after reset release
    if (!q.ld) begin
      d.ld = 1'b1;
      d.flash_option_reg = stored_option_byte;
    end
    // Address phase
    d.ap_wr = take && hwrite;
    d.ap_addr = haddr[7:0];
    d.ap_src = src_secure_code && !src_background_debug;
    d.kprev = 1'b0;
    if (take && !hwrite) begin
      d.hrdata = reg_read(haddr[7:0], q);
    end
    // Data phase of writes
    if (q.ap_wr) begin
      case (q.ap_addr)
        `FCO_OFS_CDIV: begin
          if (!q.divisor_loaded_flag) begin
            d.cdiv = hwdata[6:0];
            d.divisor_loaded_flag = 1'b1;
          end
        end
        `FCO_OFS_CTRL: begin
          if (new_kacc && q.kst == fco_pkg::FCO_KEY_IDLE) begin
            d.kst = fco_pkg::FCO_KEY_OPEN;
            d.kidx = 4'h0;
            d.kmatch = 1'b1;
          end else if (!new_kacc && q.kst == fco_pkg::FCO_KEY_OPEN) begin
            d.kst = fco_pkg::FCO_KEY_IDLE;
            // Comparison fires on closing the access window
            if (q.flash_option_reg[`FCO_BACKDOOR_KEY_ENABLE_BIT] && q.kmatch &&
                q.kidx == `FCO_KEY_BYTES) begin
              d.flash_option_reg[1:0] = `FCO_SEC_UNSEC;
            end
          end
        end
        `FCO_OFS_KEY: begin
          d.kprev = 1'b1;
          // Debug or unsecured writes leave the sequence untouched
          if (q.kst == fco_pkg::FCO_KEY_OPEN && q.ap_src) begin
            if (q.kprev || q.kidx == `FCO_KEY_BYTES) begin
              d.kmatch = 1'b0;
            end else begin
              d.kmatch = q.kmatch && (hwdata[7:0] == kbyte);
              d.kidx = q.kidx + 4'h1;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (blank_check_ok) begin
      d.flash_option_reg[1:0] = `FCO_SEC_UNSEC;
    end
    d.secure = is_secure(d.flash_option_reg[1:0]);
    d.vre = !d.flash_option_reg[`FCO_NORED_BIT];
    // Program and erase timing
    // Tick counted first, so a refused start never swallows a pulse
    if (q.busy && tick) begin
      if (q.pcnt <= 16'h1) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.pcnt = 16'h0;
      end else begin
        d.pcnt = q.pcnt - 16'h1;
      end
    end
    if (pe_start) begin
      if (!q.divisor_loaded_flag || q.busy) begin
        d.refused = 1'b1;
      end else begin
        d.busy = 1'b1;
        d.pcnt = pe_pulse_count;
      end
    end
    // Memory gate
    d.mem_we = mem_req && mem_we_in && !blocked;
    d.mem_rdata = (mem_req && !blocked) ? mem_rdata_in : 8'h00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign pe_busy_q = q.busy;
  assign pe_done_q = q.done;
  assign pe_refused_q = q.refused;
  assign fclk_tick_q = tick;
  assign flash_option_reg_q = q.flash_option_reg;
  assign secure_q = q.secure;
  assign vector_redirect_en_q = q.vre;
  assign mem_we_q = q.mem_we;
  assign mem_rdata_q = q.mem_rdata;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_divisor_loaded_flag_set;
    q.ap_wr && q.ap_addr == `FCO_OFS_CDIV |=> q.divisor_loaded_flag;
  endproperty
  a_divisor_loaded_flag_set: assert property (p_divisor_loaded_flag_set) else $error("loaded flag not set");

  property p_refuse;
    pe_start && !q.divisor_loaded_flag |=> pe_refused_q && !pe_busy_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("operation not refused");

  property p_once;
    q.divisor_loaded_flag |=> $stable(q.cdiv);
  endproperty
  a_once: assert property (p_once) else $error("divider rewritten");

  property p_tick_nodiv8;
    tick && q.divisor_loaded_flag && !q.cdiv[`FCO_PRDIV_BIT] && q.cdiv[5:0] == 6'h1 |=> !tick ##1 tick;
  endproperty
  a_tick_nodiv8: assert property (p_tick_nodiv8) else $error("divide by two wrong");

  property p_tick_div8;
    tick && q.cdiv[`FCO_PRDIV_BIT] && q.cdiv[5:0] == 6'h0 |-> ##8 tick;
  endproperty
  a_tick_div8: assert property (p_tick_div8) else $error("divide by eight wrong");

  // Last pulse ends the operation on its own tick edge
  property p_pe_len;
    q.busy && tick && q.pcnt <= 16'h1 |=> pe_done_q && !pe_busy_q;
  endproperty
  a_pe_len: assert property (p_pe_len) else $error("operation end wrong");

  // Between ticks the pulse count must not move
  property p_pe_hold;
    q.busy && !tick |=> pe_busy_q && $stable(q.pcnt);
  endproperty
  a_pe_hold: assert property (p_pe_hold) else $error("pulse count moved");

  property p_backdoor_key_enable;
    !q.flash_option_reg[`FCO_BACKDOOR_KEY_ENABLE_BIT] && !blank_check_ok && q.ld && q.secure |=> q.secure;
  endproperty
  a_backdoor_key_enable: assert property (p_backdoor_key_enable) else $error("unlock with key disabled");

  property p_dbg_key;
    q.ap_wr && q.ap_addr == `FCO_OFS_KEY && !q.ap_src |=> $stable(q.kidx);
  endproperty
  a_dbg_key: assert property (p_dbg_key) else $error("debug key write counted");

  property p_sec_code;
    q.ld |-> q.secure == (q.flash_option_reg[1:0] != `FCO_SEC_UNSEC) && q.vre == !q.flash_option_reg[`FCO_NORED_BIT];
  endproperty
  a_sec_code: assert property (p_sec_code) else $error("security decode wrong");

  property p_block;
    mem_req && q.secure && !mem_req_trusted |=> mem_rdata_q == 8'h00 && !mem_we_q;
  endproperty
  a_block: assert property (p_block) else $error("blocked access leaked");

  property p_blank;
    blank_check_ok && q.ld |=> !secure_q;
  endproperty
  a_blank: assert property (p_blank) else $error("blank check did not unlock");

  // ------------------------------------------------------------
  // Assertions on load, read back, open access and key sequence
  // ------------------------------------------------------------
  property p_divisor_loaded_flag_rst;
    !q.ld |-> !q.divisor_loaded_flag;
  endproperty
  a_divisor_loaded_flag_rst: assert property (p_divisor_loaded_flag_rst) else $error("loaded flag set early");

  property p_opt_load;
    !q.ld && !blank_check_ok |=> q.flash_option_reg == $past(stored_option_byte);
  endproperty
  a_opt_load: assert property (p_opt_load) else $error("option byte not loaded");

  // Only the key close or a blank check may alter the working options
  property p_opt_stable;
    q.ld && !blank_check_ok && !(q.ap_wr && q.ap_addr == `FCO_OFS_CTRL) |=> $stable(q.flash_option_reg);
  endproperty
  a_opt_stable: assert property (p_opt_stable) else $error("option register moved");

  property p_rd_cdiv;
    take && !hwrite && haddr[7:0] == `FCO_OFS_CDIV
      |=> hrdata == {24'h0, $past(q.divisor_loaded_flag), $past(q.cdiv)};
  endproperty
  a_rd_cdiv: assert property (p_rd_cdiv) else $error("divider read wrong");

  property p_pass;
    mem_req && !q.secure |=> mem_rdata_q == $past(mem_rdata_in) && mem_we_q == $past(mem_we_in);
  endproperty
  a_pass: assert property (p_pass) else $error("open access altered");

  property p_kidx_step;
    q.ap_wr && q.ap_addr == `FCO_OFS_KEY && q.ap_src && q.kst == fco_pkg::FCO_KEY_OPEN &&
      !q.kprev && q.kidx != `FCO_KEY_BYTES |=> q.kidx == $past(q.kidx) + 4'h1;
  endproperty
  a_kidx_step: assert property (p_kidx_step) else $error("key byte not counted");

  property p_close_unlock;
    q.ap_wr && q.ap_addr == `FCO_OFS_CTRL && !new_kacc && q.kst == fco_pkg::FCO_KEY_OPEN &&
      q.flash_option_reg[`FCO_BACKDOOR_KEY_ENABLE_BIT] && q.kmatch && q.kidx == `FCO_KEY_BYTES |=> !secure_q;
  endproperty
  a_close_unlock: assert property (p_close_unlock) else $error("key match ignored");

  // A short key must never unlock
  property p_short_key;
    q.ap_wr && q.ap_addr == `FCO_OFS_CTRL && q.kidx != `FCO_KEY_BYTES && !blank_check_ok
      |=> $stable(q.flash_option_reg);
  endproperty
  a_short_key: assert property (p_short_key) else $error("short key unlocked");

  c_div_write: cover property (q.ap_wr && q.ap_addr == `FCO_OFS_CDIV ##1 q.divisor_loaded_flag);
  c_pe_done: cover property (pe_done_q);
  c_key_unlock: cover property (q.secure ##1 !q.secure && !$past(blank_check_ok));
  c_refused: cover property (pe_refused_q);
  c_blank_unlock: cover property (blank_check_ok && q.secure);

endmodule

// ==== include/fco_defines.svh ====
// Constants of the flash clock divider and option register block
//
// Overview of operation
// - Loaded flag cleared by reset, set on write
// - Program and erase refused until flag set
// - Divider bits readable, written only once
// - Prescale bit selects bus clock or bus/8
// - Divide selected clock by divisor plus one
// - Operations last whole counts of flash ticks
// - Option byte copied into working register on first edge after reset release
// - Key enable clear blocks backdoor unlock
// - Only secure firmware key writes count
// - Ordered matching eight-byte key unlocks until reset
// - Redirect disable bit one turns redirection off
// - Only security code 1:0 means unsecured
// - Secure state blocks unsecured memory accesses
// - Key match or blank check sets code 1:0
// - Blocked writes ignored, blocked reads return zero
`ifndef FCO_DEFINES_SVH
`define FCO_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define FCO_OFS_CDIV 8'h00
`define FCO_OFS_OPT  8'h04
`define FCO_OFS_CTRL 8'h08
`define FCO_OFS_KEY  8'h0c

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define FCO_DIVISOR_LOADED_FLAG_BIT  7
`define FCO_PRDIV_BIT  6
`define FCO_BACKDOOR_KEY_ENABLE_BIT  7
`define FCO_NORED_BIT  6
`define FCO_KACC_BIT   5
`define FCO_ST_SEC_BIT 0
`define FCO_ST_BSY_BIT 1
`define FCO_ST_KEY_BIT 2
`define FCO_SEC_UNSEC  2'h2
`define FCO_PRE_LAST   3'h7
`define FCO_KEY_BYTES  4'h8
`define FCO_HTRANS_NSQ 2'h2

`endif

// ==== include/fco_pkg.sv ====
// Types of the flash clock divider and option register block
package fco_pkg;

  typedef enum logic [0:0] {
    FCO_KEY_IDLE = 1'b0,
    FCO_KEY_OPEN = 1'b1
  } fco_key_st_t;

  typedef struct packed {
    logic [2:0] pre;
    logic [5:0] cnt;
    logic       tick;
  } fco_div_state_t;

  typedef struct packed {
    logic        ld;
    logic [6:0]  cdiv;
    logic        divisor_loaded_flag;
    logic [7:0]  flash_option_reg;
    logic        secure;
    logic        vre;
    fco_key_st_t kst;
    logic [3:0]  kidx;
    logic        kmatch;
    logic        kprev;
    logic        ap_wr;
    logic [7:0]  ap_addr;
    logic        ap_src;
    logic        hready;
    logic [31:0] hrdata;
    logic        busy;
    logic [15:0] pcnt;
    logic        done;
    logic        refused;
    logic        mem_we;
    logic [7:0]  mem_rdata;
  } fco_state_t;

endpackage

// ==== rtl/fco_clkdiv.sv ====
// Flash timing tick generator: optional divide by eight, then divisor plus one
`timescale 1ns/1ps
`include "fco_defines.svh"
module fco_clkdiv (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Divider setting
  input  wire logic       run,
  input  wire logic       prescale_by_eight,
  input  wire logic [5:0] div,
  // One-cycle tick per flash clock period
  output logic            tick_q
);

  fco_pkg::fco_div_state_t q, d;
  logic src_en;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    src_en = 1'b1;
    if (prescale_by_eight) begin
      src_en = (q.pre == `FCO_PRE_LAST);
    end
    if (!run) begin
      d.pre = 3'h0;
      d.cnt = 6'h0;
    end else begin
      d.pre = q.pre + 3'h1;
      if (src_en) begin
        if (q.cnt >= div) begin
          d.cnt = 6'h0;
          d.tick = 1'b1;
        end else begin
          d.cnt = q.cnt + 6'h1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_q = q.tick;

endmodule

// ==== tb/fco_top_tb.sv ====
// Testbench of the flash clock divider and option register block
`timescale 1ns/1ps
`include "fco_defines.svh"
module fco_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, blank_check_ok, pe_start;
  logic        src_secure_code, src_background_debug, pe_busy_q, pe_done_q, pe_refused_q;
  logic        fclk_tick_q, secure_q, vector_redirect_en_q, mem_req, mem_req_trusted;
  logic        mem_we_in, mem_we_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  stored_option_byte, flash_option_reg_q, mem_rdata_in, mem_rdata_q;
  logic [15:0] pe_pulse_count;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [63:0] stored_backdoor_key;
  int          fails, compares, n, t;

  fco_top #(.KEY_BYTES(8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .src_secure_code(src_secure_code), .src_background_debug(src_background_debug),
    .stored_option_byte(stored_option_byte), .stored_backdoor_key(stored_backdoor_key),
    .blank_check_ok(blank_check_ok), .pe_start(pe_start), .pe_pulse_count(pe_pulse_count),
    .pe_busy_q(pe_busy_q), .pe_done_q(pe_done_q), .pe_refused_q(pe_refused_q),
    .fclk_tick_q(fclk_tick_q), .flash_option_reg_q(flash_option_reg_q),
    .secure_q(secure_q), .vector_redirect_en_q(vector_redirect_en_q),
    .mem_req(mem_req), .mem_req_trusted(mem_req_trusted), .mem_we_in(mem_we_in),
    .mem_rdata_in(mem_rdata_in), .mem_we_q(mem_we_q), .mem_rdata_q(mem_rdata_q)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------
  // Tasks, all entered just after a rising edge
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task results;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask

  task wait_rdy;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      results;
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= `FCO_HTRANS_NSQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(hresp, 1'b0);
  endtask

  task do_reset(input logic [7:0] opt);
    hresetn <= 1'b0;
    htrans <= 2'h0;
    stored_option_byte <= opt;
    cyc(8);
    hresetn <= 1'b1;
    cyc(2);
  endtask

  task rst_chk(input logic [7:0] opt);
    do_reset(opt);
    chk(flash_option_reg_q, opt);
    chk(secure_q, opt[1:0] != 2'h2);
    chk(vector_redirect_en_q, !opt[6]);
    rchk(`FCO_OFS_OPT, {24'h0, opt});
  endtask

  task pulse_pe(input logic [15:0] cnt);
    pe_start <= 1'b1;
    pe_pulse_count <= cnt;
    cyc(1);
    pe_start <= 1'b0;
    cyc(1);
  endtask

  // Ticks counted edge to edge, so the result is the period in bus cycles
  task period(input int exp);
    int p;
    n = 0;
    while (fclk_tick_q !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    cyc(1);
    p = 1;
    while (fclk_tick_q !== 1'b1 && p < 600) begin
      cyc(1);
      p++;
    end
    chk(p, exp);
  endtask

  task mem(input logic tr, input logic ok);
    mem_req <= 1'b1;
    mem_req_trusted <= tr;
    mem_we_in <= 1'b1;
    mem_rdata_in <= 8'ha5;
    cyc(1);
    mem_req <= 1'b0;
    mem_we_in <= 1'b0;
    cyc(1);
    chk(mem_we_q, ok);
    chk(mem_rdata_q, ok ? 8'ha5 : 8'h00);
  endtask

  // Idle cycles keep the key writes off adjacent bus cycles
  task key_seq(input logic dbg);
    src_secure_code <= 1'b1;
    src_background_debug <= dbg;
    xfer(1'b1, `FCO_OFS_CTRL, 32'h20);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      xfer(1'b1, `FCO_OFS_KEY, {24'h0, stored_backdoor_key[8*i +: 8]});
    end
    cyc(1);
    xfer(1'b1, `FCO_OFS_CTRL, 32'h0);
    cyc(3);
    src_background_debug <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, blank_check_ok, pe_start, mem_req, mem_req_trusted} = '0;
    {src_secure_code, src_background_debug, mem_we_in} = '0;
    {htrans, haddr, hwdata, mem_rdata_in, pe_pulse_count} = '0;
    hsize = 3'h2;
    stored_option_byte = 8'h00;
    stored_backdoor_key = 64'h0123456789abcdef;
    fails = 0;
    compares = 0;
    for (int i = 0; i < 4; i++) begin
      rst_chk({i[1:0], 4'h0, i[1:0]});
      xfer(1'b1, `FCO_OFS_CDIV, 32'h01);
      period(2);
    end
    rst_chk(8'h83);
    rchk(`FCO_OFS_CDIV, 32'h0);
    pulse_pe(16'h3);
    chk(pe_refused_q, 1'b1);
    chk(pe_busy_q, 1'b0);
    // Bus over 8 over 63 gives about 198 kHz before any flash operation
    xfer(1'b1, `FCO_OFS_CDIV, 32'h7e);
    rchk(`FCO_OFS_CDIV, 32'hfe);
    xfer(1'b1, `FCO_OFS_CDIV, 32'h05);
    rchk(`FCO_OFS_CDIV, 32'hfe);
    period(504);
    pulse_pe(16'h3);
    chk(pe_busy_q, 1'b1);
    t = 0;
    n = 0;
    while (pe_done_q !== 1'b1 && n < 2000) begin
      if (fclk_tick_q === 1'b1) t++;
      cyc(1);
      n++;
    end
    chk(pe_done_q, 1'b1);
    chk(pe_busy_q, 1'b0);
    chk(t, 3);
    cyc(1);
    chk(pe_done_q, 1'b0);
    mem(1'b0, 1'b0);
    mem(1'b1, 1'b1);
    key_seq(1'b1);
    chk(secure_q, 1'b1);
    key_seq(1'b0);
    chk(secure_q, 1'b0);
    rchk(`FCO_OFS_OPT, 32'h82);
    mem(1'b0, 1'b1);
    rst_chk(8'h40);
    xfer(1'b1, `FCO_OFS_CDIV, 32'h40);
    period(8);
    key_seq(1'b0);
    chk(secure_q, 1'b1);
    blank_check_ok <= 1'b1;
    cyc(1);
    blank_check_ok <= 1'b0;
    cyc(3);
    chk(secure_q, 1'b0);
    rchk(`FCO_OFS_OPT, 32'h42);
    rchk(8'h10, 32'h0);
    rchk(`FCO_OFS_KEY, 32'h0);
    rchk(`FCO_OFS_CTRL, 32'h4);
    results;
  end

  // Guards against a hang outside the bounded loops
  initial begin
    #900000;
    fails++;
    results;
  end
endmodule
